// File: dfdp_field_gate.sv
`timescale 1ns/1ps
module dfdp_field_gate
  import dfdp_pkg::*;
#(
  parameter int RATE_W = 4
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              soft_clr,
  input  wire logic              drop_en,
  input  wire logic [1:0]        drop_pat,
  input  wire logic [RATE_W-1:0] drop_rate,
  input  wire logic              field_start,
  input  wire logic              field_odd,
  output logic                   keep_q
);
  dfdp_fg_state_t    st_q, st_d;
  logic [RATE_W-1:0] cnt_q, cnt_d;
  logic              keep_d;

  function automatic logic [RATE_W:0] fg_step(input logic [RATE_W-1:0] cnt,
                                               input logic [RATE_W-1:0] rate);
    // msb is the keep decision, low bits the next skip count
    // at or above: a rate lowered mid-run must not wrap through every count
    if (cnt >= rate) fg_step = {1'b1, {RATE_W{1'b0}}};
    else fg_step = {1'b0, RATE_W'(cnt + 1'b1)};
  endfunction : fg_step

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    keep_d = keep_q;
    if (soft_clr || !drop_en) begin
      st_d   = FG_WAIT;
      cnt_d  = '0;
      keep_d = 1'b1;
    end else if (field_start) begin
      case (drop_pat[1])
        1'b0: begin
          // a frame opens only on the chosen parity; stray fields are dropped
          if (field_odd == drop_pat[0]) begin
            {keep_d, cnt_d} = fg_step(cnt_q, drop_rate);
            st_d = FG_IN;
          end else if (st_q == FG_IN) begin
            st_d = FG_WAIT;
          end else begin
            keep_d = 1'b0;
          end
        end
        default: begin
          st_d = FG_WAIT;
          if (field_odd != drop_pat[0]) keep_d = 1'b1;
          else {keep_d, cnt_d} = fg_step(cnt_q, drop_rate);
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q   <= FG_WAIT;
      cnt_q  <= '0;
      keep_q <= 1'b1;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      keep_q <= keep_d;
    end
  end

  property p_field_other_parity;
    @(posedge clk) disable iff (!arst_n)
      drop_en && !soft_clr && field_start && drop_pat[1] && (field_odd != drop_pat[0])
      |=> keep_q;
  endproperty
  a_field_other_parity: assert property (p_field_other_parity)
    else $error("field of passed parity was dropped");

  property p_frame_stray;
    @(posedge clk) disable iff (!arst_n)
      drop_en && !soft_clr && field_start && !drop_pat[1] && st_q == FG_WAIT
      && (field_odd != drop_pat[0]) |=> !keep_q;
  endproperty
  a_frame_stray: assert property (p_frame_stray)
    else $error("frame began on wrong parity");

  property p_rate_zero;
    @(posedge clk) disable iff (!arst_n)
      drop_en && !soft_clr && field_start && drop_rate == '0 && !drop_pat[1]
      && (field_odd == drop_pat[0]) |=> keep_q;
  endproperty
  a_rate_zero: assert property (p_rate_zero)
    else $error("rate zero skipped a frame");

  c_frame_skip: cover property (@(posedge clk) disable iff (!arst_n)
    drop_en && !drop_pat[1] && keep_q ##1 !keep_q);
endmodule : dfdp_field_gate

// File: dfdp_pkg.sv
package dfdp_pkg;
  localparam logic [7:0] LUMA_FILL_ADDR  = 8'h0c;
  localparam logic [7:0] CHROMA_FILL_ADDR = 8'h0d;
  localparam logic [7:0] FIELD_DROP_ADDR = 8'h0e;
  localparam logic [7:0] POWER_MGMT_ADDR = 8'h0f;

  localparam logic [7:0] LUMA_FILL_RST   = 8'h10;
  localparam logic [7:0] CHROMA_FILL_RST = 8'h88;
  localparam logic [7:0] FIELD_DROP_RST  = 8'h00;
  localparam logic [7:0] POWER_MGMT_RST  = 8'h00;

  localparam int FORCE_FILL_BIT   = 0;
  localparam int UNLOCK_FILL_BIT  = 1;
  localparam int LUMA_FILL_LSB    = 2;
  localparam int CR_NIB_LSB       = 4;
  localparam int CB_NIB_LSB       = 0;
  localparam int DROP_EN_BIT      = 0;
  localparam int DROP_PAT_LSB     = 1;
  localparam int DROP_RATE_LSB    = 3;
  localparam int DROP_RSVD_BIT    = 7;
  localparam int PSAVE_SEL_LSB    = 0;
  localparam int PD_PRIO_BIT      = 2;
  localparam int REF_SLEEP_BIT    = 3;
  localparam int LCG_SLEEP_BIT    = 4;
  localparam int CORE_PD_BIT      = 5;
  localparam int REACQ_BIT        = 6;
  localparam int SOFT_RST_BIT     = 7;

  localparam logic [1:0] PAT_FRAME_EVEN = 2'h0;
  localparam logic [1:0] PAT_FRAME_ODD  = 2'h1;
  localparam logic [1:0] PAT_DROP_EVEN  = 2'h2;
  localparam logic [1:0] PAT_DROP_ODD   = 2'h3;

  localparam logic [1:0] PSAVE_FULL     = 2'h0;
  localparam logic [1:0] PSAVE_CVBS     = 2'h1;
  localparam logic [1:0] PSAVE_DIGITAL  = 2'h2;
  localparam logic [1:0] PSAVE_SLEEP    = 2'h3;

  typedef struct packed {
    logic [7:0] y;
    logic [7:0] c;
    logic       c_is_cr;
  } dfdp_pixel_t;

  typedef enum logic [1:0] {
    FG_WAIT = 2'b01,
    FG_IN   = 2'b10
  } dfdp_fg_state_t;
endpackage : dfdp_pkg

// File: dfdp_regs.sv
`timescale 1ns/1ps
module dfdp_regs
  import dfdp_pkg::*;
#(
  parameter int RATE_W = 4
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata_q,
  input  wire logic        lock_lost,
  input  wire logic        field_start,
  input  wire logic        field_odd,
  input  wire logic        pix_valid,
  input  wire dfdp_pixel_t pix_in,
  output logic             pix_valid_q,
  output dfdp_pixel_t      pix_out_q,
  input  wire logic        powerdown_pin_n,
  output logic             core_powerdown_q,
  output logic             pads_disable_q,
  output logic             clk27_stop_q,
  output logic             reference_sleep_q,
  output logic             line_clock_gen_sleep_q,
  output logic             luma_adc_sleep_q,
  output logic             chroma_adc_sleep_q,
  output logic             timing_reacquire_q,
  output logic             core_reset_q
);
  logic [7:0]  luma_reg_q, luma_reg_d;
  logic [7:0]  chroma_reg_q, chroma_reg_d;
  logic [7:0]  drop_reg_q, drop_reg_d;
  logic [5:0]  pwr_reg_q, pwr_reg_d;
  logic        reacq_d, soft_rst_d;
  logic [7:0]  rdata_d;
  logic        pd_meta_q, pd_sync_q;
  logic        pd_d, ref_sleep_d, lcg_sleep_d, luma_sleep_d, chroma_sleep_d;
  logic        fill_act, keep;
  logic        pvalid_d;
  dfdp_pixel_t pout_d;
  logic [1:0]  psel;

  // register writes; the soft reset lands all registers on reset values
  always_comb begin
    luma_reg_d   = luma_reg_q;
    chroma_reg_d = chroma_reg_q;
    drop_reg_d   = drop_reg_q;
    pwr_reg_d    = pwr_reg_q;
    reacq_d      = 1'b0;
    soft_rst_d   = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        LUMA_FILL_ADDR:   luma_reg_d   = reg_wdata;
        CHROMA_FILL_ADDR: chroma_reg_d = reg_wdata;
        FIELD_DROP_ADDR:  drop_reg_d   = reg_wdata & ~(8'h01 << DROP_RSVD_BIT);
        POWER_MGMT_ADDR: begin
          pwr_reg_d  = reg_wdata[5:0];
          reacq_d    = reg_wdata[REACQ_BIT];
          soft_rst_d = reg_wdata[SOFT_RST_BIT];
        end
        default: ;
      endcase
    end
    if (core_reset_q) begin
      luma_reg_d   = LUMA_FILL_RST;
      chroma_reg_d = CHROMA_FILL_RST;
      drop_reg_d   = FIELD_DROP_RST;
      pwr_reg_d    = POWER_MGMT_RST[5:0];
      reacq_d      = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      luma_reg_q         <= LUMA_FILL_RST;
      chroma_reg_q       <= CHROMA_FILL_RST;
      drop_reg_q         <= FIELD_DROP_RST;
      pwr_reg_q          <= POWER_MGMT_RST[5:0];
      timing_reacquire_q <= 1'b0;
      core_reset_q       <= 1'b0;
    end else begin
      luma_reg_q         <= luma_reg_d;
      chroma_reg_q       <= chroma_reg_d;
      drop_reg_q         <= drop_reg_d;
      pwr_reg_q          <= pwr_reg_d;
      timing_reacquire_q <= reacq_d;
      core_reset_q       <= soft_rst_d;
    end
  end

  // read data; self-clearing bits show their live value
  always_comb begin
    rdata_d = reg_rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        LUMA_FILL_ADDR:   rdata_d = luma_reg_q;
        CHROMA_FILL_ADDR: rdata_d = chroma_reg_q;
        FIELD_DROP_ADDR:  rdata_d = drop_reg_q;
        POWER_MGMT_ADDR:  rdata_d = {core_reset_q, timing_reacquire_q, pwr_reg_q[5:0]};
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) reg_rdata_q <= 8'h00;
    else reg_rdata_q <= rdata_d;
  end

  // pin is asynchronous to clk, so two flops before use
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pd_meta_q <= 1'b0;
      pd_sync_q <= 1'b0;
    end else begin
      pd_meta_q <= ~powerdown_pin_n;
      pd_sync_q <= pd_meta_q;
    end
  end

  assign psel = pwr_reg_q[PSAVE_SEL_LSB +: 2];

  // one powerdown decision feeds all three outputs so they never disagree
  always_comb begin
    pd_d           = pwr_reg_q[PD_PRIO_BIT] ? pwr_reg_q[CORE_PD_BIT] : pd_sync_q;
    ref_sleep_d    = pwr_reg_q[REF_SLEEP_BIT];
    lcg_sleep_d    = pwr_reg_q[LCG_SLEEP_BIT];
    // cvbs-only idles the chroma path, digital-only idles both converters
    luma_sleep_d   = (psel == PSAVE_DIGITAL) || (psel == PSAVE_SLEEP);
    chroma_sleep_d = (psel != PSAVE_FULL);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_powerdown_q       <= 1'b0;
      pads_disable_q         <= 1'b0;
      clk27_stop_q           <= 1'b0;
      reference_sleep_q      <= 1'b0;
      line_clock_gen_sleep_q <= 1'b0;
      luma_adc_sleep_q       <= 1'b0;
      chroma_adc_sleep_q     <= 1'b0;
    end else begin
      core_powerdown_q       <= pd_d;
      pads_disable_q         <= pd_d;
      clk27_stop_q           <= pd_d;
      reference_sleep_q      <= ref_sleep_d;
      line_clock_gen_sleep_q <= lcg_sleep_d;
      luma_adc_sleep_q       <= luma_sleep_d;
      chroma_adc_sleep_q     <= chroma_sleep_d;
    end
  end

  dfdp_field_gate #(
    .RATE_W (RATE_W)
  ) u_gate (
    .clk         (clk),
    .arst_n      (arst_n),
    .soft_clr    (core_reset_q),
    .drop_en     (drop_reg_q[DROP_EN_BIT]),
    .drop_pat    (drop_reg_q[DROP_PAT_LSB +: 2]),
    .drop_rate   (drop_reg_q[DROP_RATE_LSB +: RATE_W]),
    .field_start (field_start),
    .field_odd   (field_odd),
    .keep_q      (keep)
  );

  assign fill_act = luma_reg_q[FORCE_FILL_BIT] ||
                    (luma_reg_q[UNLOCK_FILL_BIT] && lock_lost);

  always_comb begin
    pout_d   = pix_in;
    pvalid_d = pix_valid && keep;
    if (fill_act) begin
      pout_d.y = {luma_reg_q[7:LUMA_FILL_LSB], 2'b00};
      pout_d.c = pix_in.c_is_cr ? {chroma_reg_q[CR_NIB_LSB +: 4], 4'h0}
                                : {chroma_reg_q[CB_NIB_LSB +: 4], 4'h0};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pix_out_q   <= '0;
      pix_valid_q <= 1'b0;
    end else begin
      pix_out_q   <= pout_d;
      pix_valid_q <= pvalid_d;
    end
  end

  property p_force_fill;
    @(posedge clk) disable iff (!arst_n)
      luma_reg_q[FORCE_FILL_BIT] |=> pix_out_q.y == {$past(luma_reg_q[7:2]), 2'b00};
  endproperty
  a_force_fill: assert property (p_force_fill)
    else $error("forced fill luma not on output");

  property p_unlock_pass;
    @(posedge clk) disable iff (!arst_n)
      !luma_reg_q[FORCE_FILL_BIT] && !(luma_reg_q[UNLOCK_FILL_BIT] && lock_lost)
      |=> pix_out_q.y == $past(pix_in.y);
  endproperty
  a_unlock_pass: assert property (p_unlock_pass)
    else $error("video replaced while locked");

  property p_cr_fill;
    @(posedge clk) disable iff (!arst_n)
      fill_act && pix_in.c_is_cr |=> pix_out_q.c == {$past(chroma_reg_q[7:4]), 4'h0};
  endproperty
  a_cr_fill: assert property (p_cr_fill)
    else $error("cr fill byte wrong");

  property p_cb_fill;
    @(posedge clk) disable iff (!arst_n)
      fill_act && !pix_in.c_is_cr |=> pix_out_q.c == {$past(chroma_reg_q[3:0]), 4'h0};
  endproperty
  a_cb_fill: assert property (p_cb_fill)
    else $error("cb fill byte wrong");

  property p_auto_fill;
    @(posedge clk) disable iff (!arst_n)
      luma_reg_q[UNLOCK_FILL_BIT] && lock_lost
      |=> pix_out_q.y == {$past(luma_reg_q[7:2]), 2'b00};
  endproperty
  a_auto_fill: assert property (p_auto_fill)
    else $error("lock loss did not bring fill luma");

  property p_soft_reset;
    @(posedge clk) disable iff (!arst_n)
      reg_wr && reg_addr == POWER_MGMT_ADDR && reg_wdata[SOFT_RST_BIT] && !core_reset_q
      |=> core_reset_q ##1 (luma_reg_q == LUMA_FILL_RST && chroma_reg_q == CHROMA_FILL_RST
                            && drop_reg_q == FIELD_DROP_RST && !core_reset_q);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset did not restore registers");

  property p_reacquire;
    @(posedge clk) disable iff (!arst_n)
      reg_wr && reg_addr == POWER_MGMT_ADDR && reg_wdata[REACQ_BIT]
      && !reg_wdata[SOFT_RST_BIT] && !core_reset_q
      |=> timing_reacquire_q ##1 !timing_reacquire_q || $past(reg_wr);
  endproperty
  a_reacquire: assert property (p_reacquire)
    else $error("reacquire pulse wrong");

  property p_pd_bit;
    @(posedge clk) disable iff (!arst_n)
      pwr_reg_q[PD_PRIO_BIT] |=> core_powerdown_q == $past(pwr_reg_q[CORE_PD_BIT])
                                 && clk27_stop_q == core_powerdown_q;
  endproperty
  a_pd_bit: assert property (p_pd_bit)
    else $error("powerdown bit not obeyed");

  property p_pd_pin;
    @(posedge clk) disable iff (!arst_n)
      !pwr_reg_q[PD_PRIO_BIT] |=> pads_disable_q == $past(pd_sync_q);
  endproperty
  a_pd_pin: assert property (p_pd_pin)
    else $error("powerdown pin not obeyed");

  property p_drop_off;
    @(posedge clk) disable iff (!arst_n)
      !drop_reg_q[DROP_EN_BIT] ##1 pix_valid |=> pix_valid_q;
  endproperty
  a_drop_off: assert property (p_drop_off)
    else $error("field dropped while decimation off");

  property p_psave;
    @(posedge clk) disable iff (!arst_n)
      psel == PSAVE_CVBS |=> chroma_adc_sleep_q && !luma_adc_sleep_q;
  endproperty
  a_psave: assert property (p_psave)
    else $error("power save decode wrong");

  property p_ref_sleep;
    @(posedge clk) disable iff (!arst_n)
      1'b1 |=> reference_sleep_q == $past(pwr_reg_q[REF_SLEEP_BIT]);
  endproperty
  a_ref_sleep: assert property (p_ref_sleep)
    else $error("reference sleep not following its bit");

  property p_lcg_sleep;
    @(posedge clk) disable iff (!arst_n)
      1'b1 |=> line_clock_gen_sleep_q == $past(pwr_reg_q[LCG_SLEEP_BIT]);
  endproperty
  a_lcg_sleep: assert property (p_lcg_sleep)
    else $error("line clock generator sleep not following its bit");

  c_unlock_fill: cover property (@(posedge clk) disable iff (!arst_n)
    luma_reg_q[UNLOCK_FILL_BIT] && lock_lost && pix_valid);
  c_soft_reset: cover property (@(posedge clk) disable iff (!arst_n) core_reset_q);
  c_field_drop: cover property (@(posedge clk) disable iff (!arst_n)
    drop_reg_q[DROP_EN_BIT] && pix_valid && !keep);
endmodule : dfdp_regs

// File: dfdp_regs_tb_top.sv
`timescale 1ns/1ps
module dfdp_regs_tb_top;
  import dfdp_pkg::*;
  logic        clk, arst_n, reg_wr, reg_rd, lock_lost, field_start, field_odd, pix_valid;
  logic        powerdown_pin_n, rd_d, pix_valid_q, core_powerdown_q, pads_disable_q;
  logic        clk27_stop_q, reference_sleep_q, line_clock_gen_sleep_q, luma_adc_sleep_q;
  logic        chroma_adc_sleep_q, timing_reacquire_q, core_reset_q, frame_open, frame_keep;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata_q, luma_s, chroma_s, drop_s;
  dfdp_pixel_t pix_in, pix_out_q;
  logic [7:0]  rd_exp[$];
  logic [16:0] px_exp[$];
  int          errors, tests_run, seed, cnt;
  int          rates[3] = '{0, 1, 15};

  dfdp_regs #(.RATE_W(4)) DUT (.clk, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata_q, .lock_lost, .field_start, .field_odd, .pix_valid, .pix_in, .pix_valid_q,
    .pix_out_q, .powerdown_pin_n, .core_powerdown_q, .pads_disable_q, .clk27_stop_q,
    .reference_sleep_q, .line_clock_gen_sleep_q, .luma_adc_sleep_q, .chroma_adc_sleep_q,
    .timing_reacquire_q, .core_reset_q);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // results checked in arrival order against the notes the drivers left
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) begin
    if (rd_d === 1'b1) chk(17'(reg_rdata_q),
                           17'(rd_exp.size() ? rd_exp.pop_front() : 8'hxx));
    if (pix_valid_q === 1'b1) chk(17'(pix_out_q),
                                  px_exp.size() ? px_exp.pop_front() : 17'hx);
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    if (a == LUMA_FILL_ADDR) luma_s = d;
    if (a == CHROMA_FILL_ADDR) chroma_s = d;
    if (a == FIELD_DROP_ADDR) drop_s = d & 8'h7f;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rd_exp.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic settle;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // counter shared by frame and field modes: keep when count reaches rate
  task automatic step(output logic k);
    if (cnt == int'(drop_s[6:3])) begin
      k = 1'b1;
      cnt = 0;
    end else begin
      k = 1'b0;
      cnt++;
    end
  endtask : step

  task automatic field(input logic odd, input int n);
    logic        k, f, l;
    logic [7:0]  fc;
    dfdp_pixel_t p;
    if (!drop_s[0]) begin
      k = 1'b1;
      cnt = 0;
      frame_open = 1'b0;
    end else if (drop_s[2]) begin
      if (odd != drop_s[1]) k = 1'b1;
      else step(k);
    end else if (odd == drop_s[1]) begin
      step(k);
      frame_keep = k;
      frame_open = 1'b1;
    end else begin
      k = frame_open & frame_keep;
      frame_open = 1'b0;
    end
    @(posedge clk);
    field_start <= 1'b1;
    field_odd <= odd;
    for (int i = 0; i < n; i++) begin
      p = dfdp_pixel_t'(17'($random(seed)));
      l = 1'($random(seed));
      @(posedge clk);
      field_start <= 1'b0;
      pix_valid <= 1'b1;
      pix_in <= p;
      lock_lost <= l;
      f = luma_s[0] | (luma_s[1] & l);
      fc = p.c_is_cr ? {chroma_s[7:4], 4'h0} : {chroma_s[3:0], 4'h0};
      if (k) px_exp.push_back(f ? {luma_s[7:2], 2'b00, fc, p.c_is_cr} : 17'(p));
    end
    @(posedge clk);
    pix_valid <= 1'b0;
  endtask : field

  initial begin
    #200us;
    errors++;
    end_sim();
  end

  initial begin
    seed = 76;
    errors = 0;
    tests_run = 0;
    cnt = 0;
    frame_open = 1'b0;
    frame_keep = 1'b0;
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    lock_lost = 1'b0;
    field_start = 1'b0;
    field_odd = 1'b0;
    pix_valid = 1'b0;
    pix_in = '0;
    powerdown_pin_n = 1'b1;
    luma_s = 8'h10;
    chroma_s = 8'h88;
    drop_s = 8'h00;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(8'h0c, 8'h10);
    rd(8'h0d, 8'h88);
    rd(8'h0e, 8'h00);
    rd(8'h0f, 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h0e, 8'hfe);
    rd(8'h0e, 8'h7e);
    // fill modes: none, force, auto, both
    for (int m = 0; m < 4; m++) begin
      wr(8'h0c, {6'($random(seed)), 2'(m)});
      wr(8'h0d, 8'($random(seed)));
      rd(8'h0c, luma_s);
      rd(8'h0d, chroma_s);
      field(m[0], 6);
    end
    wr(8'h0c, 8'h00);
    // every pattern code at rates 0, 1 and 15, other parity first
    for (int pt = 0; pt < 4; pt++) begin
      for (int r = 0; r < 3; r++) begin
        wr(8'h0e, 8'h00);
        field(1'b0, 1);
        wr(8'h0e, {1'b1, 4'(rates[r]), 2'(pt), 1'b1});
        rd(8'h0e, drop_s);
        for (int j = 0; j < 36; j++) field(1'(j) ^ ~1'(pt), 2);
      end
    end
    wr(8'h0e, 8'h00);
    // power save select decode and sleep bits
    for (int m = 0; m < 4; m++) begin
      wr(8'h0f, {3'b000, 1'(m), 1'(m >> 1), 1'b0, 2'(m)});
      settle();
      chk(17'(luma_adc_sleep_q), 17'(m >> 1));
      chk(17'(chroma_adc_sleep_q), 17'(m != 0));
      chk(17'(reference_sleep_q), 17'(m >> 1));
      chk(17'(line_clock_gen_sleep_q), 17'(m & 1));
      rd(8'h0f, {3'b000, 1'(m), 1'(m >> 1), 1'b0, 2'(m)});
    end
    // pin has priority while PD_PRIO_BIT is clear: the bit alone must not power down; with it set the bit rules
    wr(8'h0f, 8'h20);
    settle();
    chk(17'({core_powerdown_q, pads_disable_q, clk27_stop_q}), 17'h0);
    @(posedge clk);
    powerdown_pin_n <= 1'b0;
    settle();
    chk(17'({core_powerdown_q, pads_disable_q, clk27_stop_q}), 17'h7);
    wr(8'h0f, 8'h04);
    settle();
    chk(17'({core_powerdown_q, pads_disable_q, clk27_stop_q}), 17'h0);
    @(posedge clk);
    powerdown_pin_n <= 1'b1;
    wr(8'h0f, 8'h24);
    settle();
    chk(17'({core_powerdown_q, pads_disable_q, clk27_stop_q}), 17'h7);
    wr(8'h0f, 8'h00);
    settle();
    chk(17'(core_powerdown_q), 17'h0);
    wr(8'h0f, 8'h40);
    @(negedge clk);
    chk(17'(timing_reacquire_q), 17'h1);
    @(negedge clk);
    chk(17'(timing_reacquire_q), 17'h0);
    rd(8'h0f, 8'h00);
    // soft reset returns every register to its reset value
    wr(8'h0c, 8'h57);
    wr(8'h0d, 8'h35);
    wr(8'h0e, 8'h3b);
    wr(8'h0f, 8'h9c);
    @(negedge clk);
    chk(17'(core_reset_q), 17'h1);
    @(negedge clk);
    chk(17'(core_reset_q), 17'h0);
    luma_s = 8'h10;
    chroma_s = 8'h88;
    drop_s = 8'h00;
    rd(8'h0c, 8'h10);
    rd(8'h0d, 8'h88);
    rd(8'h0e, 8'h00);
    rd(8'h0f, 8'h00);
    settle();
    chk(17'(reference_sleep_q), 17'h0);
    field(1'b1, 3);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(17'(rd_exp.size() + px_exp.size()), 17'h0);
    end_sim();
  end
endmodule : dfdp_regs_tb_top
